// ===== logic/sel_stream_error_log_keeper.sv
// Purpose: Keeps the command error, stream error and streaming performance log pages.
// Assumes: Error events come from logic on clk_sys; pages are read over Avalon-MM.
// Notes: Every access takes exactly one wait state.
`timescale 1ns/1ps
module sel_stream_error_log_keeper
(
	input  wire logic                         clk_sys,
	input  wire logic                         rst,
	input  wire logic [sel_pkg::ADDR_W-1:0]   avs_address,
	input  wire logic                         avs_read,
	input  wire logic                         avs_write,
	input  wire logic [31:0]                  avs_writedata,
	output logic [31:0]                       avs_readdata,
	output logic                              avs_waitrequest,
	input  wire sel_pkg::sel_cerr_s           cmd_err,
	input  wire sel_pkg::sel_serr_s           stream_err
);
	sel_pkg::sel_state_s s_q;
	sel_pkg::sel_state_s s_d;
	logic [1:0]          page;
	logic [8:0]          bidx;
	logic                ctrl;
	logic                req;
	logic                taken_wr;
	logic [1:0]          clr;
	logic [1:0]          hit;
	logic [7:0]          rbyte;
	logic [127:0]        ebytes;
	logic [4:0]          base_idx;
	logic [4:0]          nidx;
	logic [7:0]          sum;
	logic [7:0]          wbyte;
	logic                sel_l;

	assign page = avs_address[sel_pkg::PAGE_LSB +: 2];
	assign bidx = avs_address[sel_pkg::BYTE_LSB +: 9];
	assign ctrl = avs_address[sel_pkg::CTRL_BIT];
	assign req = avs_read | avs_write;
	assign taken_wr = avs_write & s_q.ack;
	assign avs_waitrequest = req & ~s_q.ack;
	assign avs_readdata = s_q.rdata;

	// Clear requests stand for successful completion of a log read by the command layer.
	assign clr[0] = taken_wr && avs_address == sel_pkg::REG_DONE
		&& avs_writedata[7:0] == sel_pkg::LOG_RD;
	assign clr[1] = taken_wr && avs_address == sel_pkg::REG_DONE
		&& avs_writedata[7:0] == sel_pkg::LOG_WR;
	assign hit[0] = stream_err.valid && stream_err.ent.stat[sel_pkg::STAT_SE_BIT]
		&& !stream_err.is_write;
	assign hit[1] = stream_err.valid && stream_err.ent.stat[sel_pkg::STAT_SE_BIT]
		&& stream_err.is_write;

	////////////////////////////////////////////////////////////////////////////
	// Read multiplexer: one page byte per word, upper bits zero.
	always_comb
	begin
		rbyte = '0;
		sel_l = (page == sel_pkg::PAGE_WR);
		ebytes = {16'h0000, s_q.logs[sel_l].ent[bidx[8:4]].cnt, 16'h0000,
			s_q.logs[sel_l].ent[bidx[8:4]].lba, s_q.logs[sel_l].ent[bidx[8:4]].err,
			s_q.logs[sel_l].ent[bidx[8:4]].stat, s_q.logs[sel_l].ent[bidx[8:4]].feat};
		case (page)
			sel_pkg::PAGE_CMD:
			begin
				if (bidx < 9'(sel_pkg::CER_BYTES))
					rbyte = s_q.cer[bidx[3:0]];
				else if (bidx == sel_pkg::CSUM_POS)
					rbyte = s_q.csum;
			end
			sel_pkg::PAGE_RD, sel_pkg::PAGE_WR:
			begin
				if (bidx == sel_pkg::HDR_VER)
					rbyte = sel_pkg::VERSION;
				else if (bidx == sel_pkg::HDR_IDX)
					rbyte = {3'h0, s_q.logs[sel_l].idx};
				else if (bidx == sel_pkg::HDR_CNT_LO)
					rbyte = s_q.logs[sel_l].cnt[7:0];
				else if (bidx == sel_pkg::HDR_CNT_HI)
					rbyte = s_q.logs[sel_l].cnt[15:8];
				else if (bidx >= sel_pkg::ENT_BASE)
					rbyte = ebytes[{bidx[3:0], 3'h0} +: 8];
			end
			sel_pkg::PAGE_PERF:
			begin
				case (bidx)
					9'h002: rbyte = sel_pkg::PERF_K[7:0];
					9'h003: rbyte = sel_pkg::PERF_K[15:8];
					9'h004: rbyte = sel_pkg::PERF_L[7:0];
					9'h005: rbyte = sel_pkg::PERF_L[15:8];
					9'h006: rbyte = sel_pkg::PERF_M[7:0];
					9'h007: rbyte = sel_pkg::PERF_M[15:8];
					default:
					begin
						if (bidx < sel_pkg::PERF_BYTES)
							rbyte = s_q.perf[bidx[4:0]];
					end
				endcase
			end
			default: rbyte = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb
	begin
		s_d = s_q;
		base_idx = '0;
		nidx = '0;
		sum = '0;
		wbyte = avs_writedata[7:0];
		s_d.ack = req & ~s_q.ack;
		if (avs_read && !s_q.ack)
		begin
			s_d.rdata = '0;
			if (!ctrl)
				s_d.rdata[7:0] = rbyte;
			else if (avs_address == sel_pkg::REG_STATUS)
				s_d.rdata = {s_q.logs[1].cnt, s_q.logs[0].cnt};
		end

		// Position numbers are held below 2^63 by dropping the top bit on entry.
		if (taken_wr && !ctrl && page == sel_pkg::PAGE_PERF && bidx >= sel_pkg::PERF_HDR
			&& bidx < sel_pkg::PERF_BYTES)
		begin
			if (bidx >= sel_pkg::PERF_POS && bidx < sel_pkg::PERF_ACC && bidx[2:0] == sel_pkg::POS_MSB_OFS)
				wbyte[7] = 1'b0;
			s_d.perf[bidx[4:0]] = wbyte;
		end
		if (taken_wr && !ctrl && page == sel_pkg::PAGE_PERF && bidx < sel_pkg::HDR_CNT_LO)
			s_d.perf[bidx[4:0]] = wbyte;

		for (int l = 0; l < 2; l++)
		begin
			if (clr[l])
			begin
				s_d.logs[l] = '0;
			end
			// A new error in the clearing cycle survives as the first entry.
			if (hit[l])
			begin
				base_idx = clr[l] ? 5'h00 : s_q.logs[l].idx;
				nidx = (base_idx == sel_pkg::IDX_MAX) ? sel_pkg::IDX_FIRST
					: base_idx + sel_pkg::IDX_FIRST;
				s_d.logs[l].idx = nidx;
				if (clr[l])
					s_d.logs[l].cnt = 16'h0001;
				else if (s_q.logs[l].cnt != sel_pkg::CNT_MAX)
					s_d.logs[l].cnt = s_q.logs[l].cnt + 16'h0001;
				s_d.logs[l].ent[nidx] = stream_err.ent;
				if (stream_err.deferred)
					s_d.logs[l].ent[nidx].feat = sel_pkg::DEFER_FEAT;
			end
		end

		if (cmd_err.valid)
		begin
			s_d.cer[0] = {cmd_err.non_queued_flag, 2'h0, cmd_err.tag};
			for (int i = 1; i < sel_pkg::CER_BYTES; i++)
				s_d.cer[i] = cmd_err.shadow[i-1];
			s_d.cer[sel_pkg::CER_RSV_A] = '0;
			s_d.cer[sel_pkg::CER_RSV_B] = '0;
			for (int i = 0; i < sel_pkg::CER_BYTES; i++)
				sum = sum + s_d.cer[i];
			s_d.csum = 8'h00 - sum;
		end
	end

	// Synchronous reset doubles as the hardware reset that empties both logs.
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	logic [7:0] chk_sum;
	always_comb
	begin
		chk_sum = s_q.csum;
		for (int i = 0; i < sel_pkg::CER_BYTES; i++)
			chk_sum = chk_sum + s_q.cer[i];
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	csum_zero_a: assert property (chk_sum == 8'h00)
		else $error("command error record does not sum to zero");
	nq_byte_a: assert property (cmd_err.valid |=> s_q.cer[0] ==
		{$past(cmd_err.non_queued_flag), 2'h0, $past(cmd_err.tag)})
		else $error("command error byte 0 wrong");
	rd_index_range_a: assert property ((s_q.logs[0].cnt != 16'h0000) == (s_q.logs[0].idx != 5'h00))
		else $error("read log index outside 1..31 while entries exist");
	gate_flag_a: assert property (stream_err.valid && !stream_err.ent.stat[sel_pkg::STAT_SE_BIT]
		&& !clr[0] |=> $stable(s_q.logs[0].cnt))
		else $error("entry logged without stream error flag");
	count_sat_a: assert property (s_q.logs[0].cnt == sel_pkg::CNT_MAX && !clr[0] |=>
		s_q.logs[0].cnt == sel_pkg::CNT_MAX)
		else $error("read stream count wrapped");
	rd_clear_a: assert property (clr[0] && !hit[0] |=> s_q.logs[0].cnt == 16'h0000
		&& s_q.logs[0].idx == 5'h00)
		else $error("read log not cleared after read");
	wr_clear_a: assert property (clr[1] && hit[1] |=> s_q.logs[1].cnt == 16'h0001
		&& s_q.logs[1].idx == sel_pkg::IDX_FIRST)
		else $error("write log lost error in clearing cycle");
	idx_wrap_a: assert property (hit[0] && !clr[0] && s_q.logs[0].idx == sel_pkg::IDX_MAX |=>
		s_q.logs[0].idx == sel_pkg::IDX_FIRST)
		else $error("read log index did not wrap");
	defer_feat_a: assert property (hit[1] && stream_err.deferred |=>
		s_q.logs[1].ent[s_q.logs[1].idx].feat == sel_pkg::DEFER_FEAT)
		else $error("deferred write feature not forced");
	version_read_a: assert property (avs_read && !ctrl && page == sel_pkg::PAGE_RD
		&& bidx == sel_pkg::HDR_VER && !s_q.ack |=> avs_readdata == {24'h0, sel_pkg::VERSION}
		&& !avs_waitrequest)
		else $error("stream log version byte wrong");


	////////////////////////////////////////////////////////////////////////////
	// Count and index bookkeeping of both stream logs.
	wr_index_range_a: assert property ((s_q.logs[1].cnt != 16'h0000)
		== (s_q.logs[1].idx != 5'h00))
		else $error("write log index outside its range while entries exist");

	wr_count_sat_a: assert property (s_q.logs[1].cnt == sel_pkg::CNT_MAX && !clr[1]
		|=> s_q.logs[1].cnt == sel_pkg::CNT_MAX)
		else $error("write stream count wrapped");

	wr_clear_only_a: assert property (clr[1] && !hit[1]
		|=> s_q.logs[1].cnt == 16'h0000 && s_q.logs[1].idx == 5'h00)
		else $error("write log not cleared after read");

	rd_clear_hit_a: assert property (clr[0] && hit[0]
		|=> s_q.logs[0].cnt == 16'h0001 && s_q.logs[0].idx == sel_pkg::IDX_FIRST)
		else $error("read log lost error in clearing cycle");

	rd_count_inc_a: assert property (hit[0] && !clr[0] && s_q.logs[0].cnt != sel_pkg::CNT_MAX
		|=> s_q.logs[0].cnt == $past(s_q.logs[0].cnt) + 16'h0001)
		else $error("read stream count did not step");

	wr_count_inc_a: assert property (hit[1] && !clr[1] && s_q.logs[1].cnt != sel_pkg::CNT_MAX
		|=> s_q.logs[1].cnt == $past(s_q.logs[1].cnt) + 16'h0001)
		else $error("write stream count did not step");

	wr_gate_flag_a: assert property (stream_err.valid && !stream_err.ent.stat[sel_pkg::STAT_SE_BIT]
		&& !clr[1] |=> $stable(s_q.logs[1].cnt))
		else $error("write entry logged without stream error flag");

	rd_count_hold_a: assert property (!hit[0] && !clr[0]
		|=> $stable(s_q.logs[0].cnt))
		else $error("read stream count moved without an error");

	wr_count_hold_a: assert property (!hit[1] && !clr[1]
		|=> $stable(s_q.logs[1].cnt))
		else $error("write stream count moved without an error");

	rd_idx_hold_a: assert property (!hit[0] && !clr[0]
		|=> $stable(s_q.logs[0].idx))
		else $error("read log index moved without an error");

	rd_idx_step_a: assert property (hit[0] && !clr[0] && s_q.logs[0].idx != sel_pkg::IDX_MAX
		|=> s_q.logs[0].idx == $past(s_q.logs[0].idx) + 5'h01)
		else $error("read log index did not advance by one");

	wr_idx_step_a: assert property (hit[1] && !clr[1] && s_q.logs[1].idx != sel_pkg::IDX_MAX
		|=> s_q.logs[1].idx == $past(s_q.logs[1].idx) + 5'h01)
		else $error("write log index did not advance by one");

	////////////////////////////////////////////////////////////////////////////
	// Entry capture: the newest slot holds what the error event carried, except the feature of a deferred event.
	rd_entry_lba_a: assert property (hit[0]
		|=> s_q.logs[0].ent[s_q.logs[0].idx].lba == $past(stream_err.ent.lba))
		else $error("read entry address not captured");

	rd_entry_cnt_a: assert property (hit[0]
		|=> s_q.logs[0].ent[s_q.logs[0].idx].cnt == $past(stream_err.ent.cnt))
		else $error("read entry sector count not captured");

	rd_entry_stat_a: assert property (hit[0]
		|=> s_q.logs[0].ent[s_q.logs[0].idx].stat == $past(stream_err.ent.stat))
		else $error("read entry status not captured");

	rd_entry_err_a: assert property (hit[0]
		|=> s_q.logs[0].ent[s_q.logs[0].idx].err == $past(stream_err.ent.err))
		else $error("read entry error byte not captured");

	rd_entry_feat_a: assert property (hit[0] && !stream_err.deferred
		|=> s_q.logs[0].ent[s_q.logs[0].idx].feat == $past(stream_err.ent.feat))
		else $error("read entry feature not captured");

	wr_entry_lba_a: assert property (hit[1]
		|=> s_q.logs[1].ent[s_q.logs[1].idx].lba == $past(stream_err.ent.lba))
		else $error("write entry address not captured");

	wr_entry_cnt_a: assert property (hit[1]
		|=> s_q.logs[1].ent[s_q.logs[1].idx].cnt == $past(stream_err.ent.cnt))
		else $error("write entry sector count not captured");

	wr_entry_stat_a: assert property (hit[1]
		|=> s_q.logs[1].ent[s_q.logs[1].idx].stat == $past(stream_err.ent.stat))
		else $error("write entry status not captured");

	wr_entry_feat_a: assert property (hit[1] && !stream_err.deferred
		|=> s_q.logs[1].ent[s_q.logs[1].idx].feat == $past(stream_err.ent.feat))
		else $error("write entry feature not captured");

	////////////////////////////////////////////////////////////////////////////
	// Command error record. It only changes when a new error is reported.
	cer_nq_a: assert property (cmd_err.valid
		|=> s_q.cer[0][7] == $past(cmd_err.non_queued_flag))
		else $error("non-queued flag not captured");

	cer_rsv_bits_a: assert property (s_q.cer[0][6:5] == 2'h0)
		else $error("reserved bits of command error byte 0 set");

	cer_first_a: assert property (cmd_err.valid
		|=> s_q.cer[2] == $past(cmd_err.shadow[1]))
		else $error("first shadow byte not captured");

	cer_last_a: assert property (cmd_err.valid
		|=> s_q.cer[sel_pkg::CER_BYTES-1] == $past(cmd_err.shadow[12]))
		else $error("last shadow byte not captured");

	cer_rsv_a: assert property (s_q.cer[sel_pkg::CER_RSV_A] == 8'h00
		&& s_q.cer[sel_pkg::CER_RSV_B] == 8'h00)
		else $error("reserved command error byte not zero");

	cer_hold_a: assert property (!cmd_err.valid
		|=> $stable(s_q.cer) && $stable(s_q.csum))
		else $error("command error record changed without an error");

	////////////////////////////////////////////////////////////////////////////
	// Read path: the word handed back holds the byte or status word standing at the request.
	rd_cnt_read_a: assert property (avs_read && !ctrl && page == sel_pkg::PAGE_RD
		&& bidx == sel_pkg::HDR_CNT_LO && !s_q.ack |=> avs_readdata == {24'h0, $past(s_q.logs[0].cnt[7:0])})
		else $error("read log count byte wrong");

	rd_idx_read_a: assert property (avs_read && !ctrl && page == sel_pkg::PAGE_RD
		&& bidx == sel_pkg::HDR_IDX && !s_q.ack |=> avs_readdata == {27'h0, $past(s_q.logs[0].idx)})
		else $error("read log index byte wrong");

	wr_version_read_a: assert property (avs_read && !ctrl && page == sel_pkg::PAGE_WR
		&& bidx == sel_pkg::HDR_VER && !s_q.ack |=> avs_readdata == {24'h0, sel_pkg::VERSION})
		else $error("write log version byte wrong");

	csum_read_a: assert property (avs_read && !ctrl && page == sel_pkg::PAGE_CMD
		&& bidx == sel_pkg::CSUM_POS && !s_q.ack |=> avs_readdata == {24'h0, $past(s_q.csum)})
		else $error("checksum byte read wrong");

	status_read_a: assert property (avs_read && avs_address == sel_pkg::REG_STATUS && !s_q.ack
		|=> avs_readdata == {$past(s_q.logs[1].cnt), $past(s_q.logs[0].cnt)})
		else $error("status word wrong");

	////////////////////////////////////////////////////////////////////////////
	// Performance page. The counts are fixed, so writes to them must not land.
	perf_k_read_a: assert property (avs_read && !ctrl && page == sel_pkg::PAGE_PERF
		&& bidx == sel_pkg::HDR_CNT_LO && !s_q.ack |=> avs_readdata == {24'h0, sel_pkg::PERF_K[7:0]})
		else $error("performance page K byte wrong");

	perf_rsv_read_a: assert property (avs_read && !ctrl && page == sel_pkg::PAGE_PERF
		&& bidx == sel_pkg::PERF_BYTES && !s_q.ack |=> avs_readdata == 32'h0)
		else $error("performance page reserved fill not zero");

	perf_hdr_hold_a: assert property (taken_wr && !ctrl && page == sel_pkg::PAGE_PERF
		&& bidx == sel_pkg::HDR_CNT_LO |=> $stable(s_q.perf))
		else $error("performance page count byte was written");

	pos_msb_a: assert property (s_q.perf[5'(sel_pkg::PERF_POS + 9'(sel_pkg::POS_MSB_OFS))][7] == 1'b0)
		else $error("position number above its limit");

	wr_defer_c: cover property (hit[1] && stream_err.deferred);
	sat_seen_c: cover property (hit[0] && s_q.logs[0].cnt == sel_pkg::CNT_MAX);
	wrap_seen_c: cover property (hit[0] && s_q.logs[0].idx == sel_pkg::IDX_MAX);
	clear_hit_c: cover property (clr[0] && hit[0]);
	cmd_err_c: cover property (cmd_err.valid ##2 avs_read && page == sel_pkg::PAGE_CMD);
endmodule

// ===== logic/sel_pkg.sv
// Purpose: Constants and types for the stream error log keeper.
// Assumes: One 200 MHz clock domain, synchronous active-high reset.
// Notes: Log pages are read one byte per Avalon word.
package sel_pkg;
	localparam int          SLOTS        = 31;
	localparam int          ADDR_W       = 14;
	localparam logic [7:0]  LOG_PERF     = 8'h20;
	localparam logic [7:0]  LOG_WR       = 8'h21;
	localparam logic [7:0]  LOG_RD       = 8'h22;
	localparam logic [7:0]  VERSION      = 8'h02;
	localparam int          STAT_SE_BIT  = 5;
	localparam logic [15:0] DEFER_FEAT   = 16'hffff;
	localparam logic [15:0] CNT_MAX      = 16'hffff;
	localparam logic [4:0]  IDX_MAX      = 5'h1f;
	localparam logic [4:0]  IDX_FIRST    = 5'h01;
	localparam logic [1:0]  PAGE_CMD     = 2'h0;
	localparam logic [1:0]  PAGE_RD      = 2'h1;
	localparam logic [1:0]  PAGE_WR      = 2'h2;
	localparam logic [1:0]  PAGE_PERF    = 2'h3;
	localparam int          CTRL_BIT     = 13;
	localparam int          PAGE_LSB     = 11;
	localparam int          BYTE_LSB     = 2;
	localparam logic [13:0] REG_DONE     = 14'h2000;
	localparam logic [13:0] REG_STATUS   = 14'h2004;
	localparam int          CER_BYTES    = 14;
	localparam int          CER_RSV_A    = 1;
	localparam int          CER_RSV_B    = 11;
	localparam logic [8:0]  CSUM_POS     = 9'h1ff;
	localparam logic [8:0]  HDR_VER      = 9'h000;
	localparam logic [8:0]  HDR_IDX      = 9'h001;
	localparam logic [8:0]  HDR_CNT_LO   = 9'h002;
	localparam logic [8:0]  HDR_CNT_HI   = 9'h003;
	localparam logic [8:0]  ENT_BASE     = 9'h010;
	localparam logic [15:0] PERF_K       = 16'h0001;
	localparam logic [15:0] PERF_L       = 16'h0001;
	localparam logic [15:0] PERF_M       = 16'h0001;
	localparam logic [8:0]  PERF_HDR     = 9'h008;
	localparam logic [8:0]  PERF_POS     = 9'h010;
	localparam logic [8:0]  PERF_ACC     = 9'h018;
	localparam logic [8:0]  PERF_BYTES   = 9'h01c;
	localparam logic [2:0]  POS_MSB_OFS  = 3'h7;

	typedef struct packed {
		logic [15:0] cnt;
		logic [47:0] lba;
		logic [7:0]  err;
		logic [7:0]  stat;
		logic [15:0] feat;
	} sel_entry_s;

	typedef struct packed {
		logic        valid;
		logic        is_write;
		logic        deferred;
		sel_entry_s  ent;
	} sel_serr_s;

	typedef struct packed {
		logic             valid;
		logic             non_queued_flag;
		logic [4:0]       tag;
		logic [12:0][7:0] shadow;
	} sel_cerr_s;

	typedef struct packed {
		logic [4:0]             idx;
		logic [15:0]            cnt;
		sel_entry_s [SLOTS:1]   ent;
	} sel_log_s;

	typedef struct packed {
		sel_log_s [1:0]                 logs;
		logic [CER_BYTES-1:0][7:0]      cer;
		logic [7:0]                     csum;
		logic [PERF_BYTES-1:0][7:0]     perf;
		logic                           ack;
		logic [31:0]                    rdata;
	} sel_state_s;
endpackage

// ===== dv/sel_host_model.sv
// Purpose: Host side model that reads log pages and writes control over Avalon-MM.
// Assumes: One clock; the slave answers after a wait state of its own choosing.
// Notes: Waitrequest is sampled at each rising edge; the request is released only after it is seen low there.
`timescale 1ns/1ps
module sel_host_model
(
	input  wire logic        clk_sys,
	output logic [13:0]      avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic [31:0]      avs_writedata,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest
);
////////////////////////////////////////////////////////////
	initial
	begin
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
	end
	task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= d;
		@(posedge clk_sys);
		while (avs_waitrequest)
			@(posedge clk_sys);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	function automatic logic [15:0] plan_time(input logic [15:0] own, input logic [15:0] dev);
		return (own > dev) ? own : dev;
	endfunction
endmodule

// ===== dv/tb_top.sv
// Purpose: Self-checking bench for the stream error log keeper.
// Assumes: The host model drives the bus; error events are pulsed here.
// Notes: The saturation test runs about 65k cycles, which sets the timeout.
`timescale 1ns/1ps
module tb_top;
	logic               clk_sys;
	logic               rst;
	logic [13:0]        adr;
	logic               rd_en;
	logic               wr_en;
	logic [31:0]        wdat;
	logic [31:0]        rdat;
	logic               wait_r;
	sel_pkg::sel_cerr_s cmd_err;
	sel_pkg::sel_serr_s serr_in;
	int                 fail_count;
	int                 samples_checked;
	int                 cycles;
	logic [31:0]        v;
	logic [7:0]         sum;
	logic [7:0]         e;
	sel_stream_error_log_keeper dut (.clk_sys(clk_sys), .rst(rst), .avs_address(adr), .avs_read(rd_en),
		.avs_write(wr_en), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_r),
		.cmd_err(cmd_err), .stream_err(serr_in));
	sel_host_model host (.clk_sys(clk_sys), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
		.avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_r));
////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s: %h not %h", $time, what, seen, exp);
		end
	endtask
	task automatic rb(input logic [1:0] p, input int b, input logic [7:0] x);
		host.xfer(1'b0, {1'b0, p, 9'(b), 2'b00}, '0, v);
		chk(v, {24'h0, x}, "page byte");
	endtask
	task automatic wb(input logic [1:0] p, input int b, input logic [7:0] x);
		host.xfer(1'b1, {1'b0, p, 9'(b), 2'b00}, {24'h0, x}, v);
	endtask
	// Every event carries its number k in count, address and feature so that slots can be told apart.
	task automatic ev(input logic w, input logic d, input logic [7:0] st, input int k);
		@(posedge clk_sys);
		serr_in <= '{1'b1, w, d, '{16'(k), 48'h0a0b0c0d0e00 + 48'(k), 8'h04, st, 16'h1000 + 16'(k)}};
		@(posedge clk_sys);
		serr_in.valid <= 1'b0;
	endtask
	task automatic ent(input logic [1:0] p, input int s, input int k, input logic [15:0] f, input logic [7:0] st);
		logic [47:0] a;
		a = 48'h0a0b0c0d0e00 + 48'(k);
		rb(p, s*16, f[7:0]);
		rb(p, s*16+1, f[15:8]);
		rb(p, s*16+2, st);
		rb(p, s*16+3, 8'h04);
		for (int i = 0; i < 6; i++)
			rb(p, s*16+4+i, a[8*i+:8]);
		rb(p, s*16+12, 8'(k));
		rb(p, s*16+13, 8'(k >> 8));
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 80000)
		begin
			fail_count++;
			give_verdict();
		end
	end
////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		cmd_err = '0;
		serr_in = '0;
		fail_count = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
		for (int p = 1; p < 3; p++)
		begin
			rb(2'(p), 0, 8'h02);
			rb(2'(p), 1, 8'h00);
		end
		$display("test empty pages done");
		for (int q = 0; q < 2; q++)
		begin
			@(posedge clk_sys);
			cmd_err.valid <= 1'b1;
			cmd_err.non_queued_flag <= q[0];
			cmd_err.tag <= q ? 5'h0a : 5'h13;
			for (int i = 0; i < 13; i++)
				cmd_err.shadow[i] <= 8'h30 + 8'(i) + 8'(q);
			@(posedge clk_sys);
			cmd_err.valid <= 1'b0;
			sum = 8'h00;
			for (int i = 0; i < 14; i++)
			begin
				e = (i == 0) ? {q[0], 2'b00, q ? 5'h0a : 5'h13} : (i == 1 || i == 11) ? 8'h00 : 8'h30 + 8'(i - 1 + q);
				sum = sum + e;
				rb(sel_pkg::PAGE_CMD, i, e);
			end
			rb(sel_pkg::PAGE_CMD, 511, -sum);
		end
		$display("test command record done");
		ev(1'b0, 1'b0, 8'h01, 99);
		rb(sel_pkg::PAGE_RD, 2, 8'h00);
		for (int k = 1; k <= 33; k++)
			ev(1'b0, 1'b0, 8'h21, k);
		rb(sel_pkg::PAGE_RD, 1, 8'h02);
		rb(sel_pkg::PAGE_RD, 2, 8'h21);
		ent(sel_pkg::PAGE_RD, 2, 33, 16'h1021, 8'h21);
		ent(sel_pkg::PAGE_RD, 3, 3, 16'h1003, 8'h21);
		rb(sel_pkg::PAGE_RD, 'h1f0, 8'h1f);
		ev(1'b1, 1'b1, 8'h20, 5);
		rb(sel_pkg::PAGE_WR, 1, 8'h01);
		ent(sel_pkg::PAGE_WR, 1, 5, 16'hffff, 8'h20);
		$display("test capture and wrap done");
		host.xfer(1'b1, sel_pkg::REG_DONE, 32'h22, v);
		rb(sel_pkg::PAGE_RD, 1, 8'h00);
		rb(sel_pkg::PAGE_RD, 2, 8'h00);
		rb(sel_pkg::PAGE_WR, 2, 8'h01);
		host.xfer(1'b1, sel_pkg::REG_DONE, 32'h21, v);
		rb(sel_pkg::PAGE_WR, 1, 8'h00);
		rb(sel_pkg::PAGE_WR, 2, 8'h00);
		host.xfer(1'b0, 14'h2008, '0, v);
		chk(v, 32'h0, "unmapped");
		$display("test clear done");
		fork
			host.xfer(1'b1, sel_pkg::REG_DONE, 32'h21, v);
			begin
				@(posedge clk_sys);
				ev(1'b1, 1'b0, 8'h20, 7);
			end
		join
		rb(sel_pkg::PAGE_WR, 1, 8'h01);
		rb(sel_pkg::PAGE_WR, 2, 8'h01);
		$display("test clear with error done");
		@(posedge clk_sys);
		serr_in <= '{1'b1, 1'b0, 1'b0, '{16'h1, 48'h7, 8'h04, 8'h20, 16'h0}};
		repeat (65537) @(posedge clk_sys);
		serr_in.valid <= 1'b0;
		rb(sel_pkg::PAGE_RD, 2, 8'hff);
		rb(sel_pkg::PAGE_RD, 3, 8'hff);
		rb(sel_pkg::PAGE_RD, 1, 8'h03);
		host.xfer(1'b0, sel_pkg::REG_STATUS, '0, v);
		chk(v, 32'h0001ffff, "status counts");
		$display("test saturation done");
		for (int b = 2; b < 8; b++)
			rb(sel_pkg::PAGE_PERF, b, b[0] ? 8'h00 : 8'h01);
		wb(sel_pkg::PAGE_PERF, 2, 8'h77);
		rb(sel_pkg::PAGE_PERF, 2, 8'h01);
		wb(sel_pkg::PAGE_PERF, 23, 8'hff);
		rb(sel_pkg::PAGE_PERF, 23, 8'h7f);
		wb(sel_pkg::PAGE_PERF, 14, 8'h5a);
		rb(sel_pkg::PAGE_PERF, 14, 8'h5a);
		wb(sel_pkg::PAGE_PERF, 26, 8'hc3);
		rb(sel_pkg::PAGE_PERF, 26, 8'hc3);
		rb(sel_pkg::PAGE_PERF, 28, 8'h00);
		$display("test performance page done");
		give_verdict();
	end
endmodule
